// ==== rtl/debug_run_status_logic.sv ====
// Summary of operation
// - Comparator A match flag in bit 7 clears at run start and sets on any A match while the run is active.
// - Comparator B match flag in bit 6 clears at run start and sets on any B match while the run is active.
// - With debug enable set, armed flag in bit 5 mirrors the arm control bit.
// - Host arms by writing arm=1 with enable set, and the armed flag then reads set.
// - A run ends by itself on FIFO full in begin trace or on a trigger in end trace.
// - Writing 0 to arm or to debug enable ends an active run at once.
// - Count in bits 3:0 clears at run start and holds the captured word total at run end.
// - Host reads of the FIFO never decrement the count.
// - Count is plain binary, 0000 for empty up to 1000 for eight words.
// - Trace begin select picks end trace (0, circular until trigger) or begin trace (1).
// - The status register is read-only and ignores writes.
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "debug_run_defines.svh"
module debug_run_status_logic (
  input  wire logic                          clk_i,
  input  wire logic                          sys_rst_i,
  input  wire logic                          hsel_i,
  input  wire logic [`ADDR_W-1:0]            haddr_i,
  input  wire logic [1:0]                    htrans_i,
  input  wire logic                          hwrite_i,
  input  wire logic [2:0]                    hsize_i,
  input  wire logic                          hready_i,
  input  wire logic [31:0]                   hwdata_i,
  input  wire debug_run_pkg::debug_events_t  events_i,
  output      logic                          hreadyout_o,
  output      logic [31:0]                   hrdata_o,
  output      logic                          hresp_o,
  output      logic                          armed_o,
  output      logic                          capture_o,
  output      logic                          irq_o
);
  import debug_run_pkg::*;

  localparam int IRQ_N = `IRQ_COUNT;

  reg_access_t        acc;
  ahb_addr_t          aphase;
  logic [31:0]        rd_data;
  logic               enable_reg;
  logic               arm_reg;
  logic               begin_sel_reg;
  logic               mode_begin_reg;
  logic               flag_a_reg;
  logic               flag_b_reg;
  logic [3:0]         count_reg;
  logic [3:0]         count_next;
  run_state_t         state_reg;
  run_state_t         state_next;
  logic [IRQ_N-1:0]   irq_status;
  logic [IRQ_N-1:0]   irq_enable;
  logic [IRQ_N-1:0]   irq_events;
  logic [7:0]         status_byte;
  logic               irq_line;

  // Address phase bundle; transfer size is always a full word
  assign aphase = '{sel: hsel_i, trans: htrans_i, write: hwrite_i, addr: haddr_i};

  ahb_reg_port u_port (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .aphase_i    (aphase),
    .hready_i    (hready_i),
    .hwdata_i    (hwdata_i),
    .rd_data_i   (rd_data),
    .acc_o       (acc),
    .hreadyout_o (hreadyout_o),
    .hrdata_o    (hrdata_o),
    .hresp_o     (hresp_o)
  );

  // Register write decode
  wire wr_ctl = acc.wr & (acc.addr == `OFS_CONTROL);
  wire wr_clr = acc.wr & (acc.addr == `OFS_IRQ_CLEAR);
  wire wr_ien = acc.wr & (acc.addr == `OFS_IRQ_ENABLE);
  wire new_en  = acc.data[`CTL_EN_BIT];
  wire new_arm = acc.data[`CTL_ARM_BIT] & new_en;

  // Run start and manual stop from control writes
  wire active     = (state_reg != RUN_IDLE);
  wire start_run  = wr_ctl & new_arm & ~active;
  wire manual_end = wr_ctl & active & ~new_arm;

  // Run mode taken at run start; later control writes leave it alone
  always_ff @(posedge clk_i) begin
    if (sys_rst_i)
      mode_begin_reg <= 1'b0;
    else if (start_run)
      mode_begin_reg <= begin_sel_reg;
  end

  // Capture bookkeeping
  wire count_full = (count_reg == `CNT_FULL);
  wire store      = (state_reg == RUN_CAPTURE) & events_i.word;
  wire fill_end   = mode_begin_reg & store & (count_reg == `CNT_FULL - `CNT_ONE);
  wire trig_end   = ~mode_begin_reg & (state_reg == RUN_CAPTURE) & events_i.trigger;
  wire auto_end   = fill_end | trig_end;
  wire run_end    = active & (auto_end | manual_end);

  // Run state sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      RUN_IDLE: begin
        if (start_run)
          state_next = begin_sel_reg ? RUN_WAIT_TRIG : RUN_CAPTURE;
      end
      RUN_WAIT_TRIG: begin
        if (manual_end)
          state_next = RUN_IDLE;
        else if (events_i.trigger)
          state_next = RUN_CAPTURE;
      end
      RUN_CAPTURE: begin
        if (run_end)
          state_next = RUN_IDLE;
      end
      default: state_next = RUN_IDLE;
    endcase
  end

  // Saturating binary word count
  always_comb begin
    count_next = count_reg;
    if (start_run)
      count_next = `CNT_EMPTY;
    else if (store && !count_full)
      count_next = count_reg + `CNT_ONE;
  end

  // Run state and count registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= RUN_IDLE;
      count_reg <= `CNT_EMPTY;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // Control register, arm drops when the run ends
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      enable_reg    <= 1'b0;
      arm_reg       <= 1'b0;
      begin_sel_reg <= 1'b0;
    end else if (wr_ctl) begin
      enable_reg    <= new_en;
      arm_reg       <= new_arm & ~run_end;
      begin_sel_reg <= acc.data[`CTL_BEGIN_BIT];
    end else if (run_end) begin
      arm_reg       <= 1'b0;
    end
  end

  // Match flags, cleared at start, sticky until next run
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flag_a_reg <= 1'b0;
      flag_b_reg <= 1'b0;
    end else if (start_run) begin
      flag_a_reg <= 1'b0;
      flag_b_reg <= 1'b0;
    end else if (active) begin
      flag_a_reg <= flag_a_reg | events_i.cmp_a;
      flag_b_reg <= flag_b_reg | events_i.cmp_b;
    end
  end

  // Status byte and armed output, armed flag is enable and arm
  assign status_byte = {flag_a_reg, flag_b_reg, enable_reg & arm_reg, 1'b0, count_reg};

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      armed_o   <= 1'b0;
      capture_o <= 1'b0;
    end else begin
      armed_o   <= (state_next != RUN_IDLE);
      capture_o <= (state_next == RUN_CAPTURE);
    end
  end

  // Interrupt events: run end, A match, B match
  assign irq_events[`IRQ_RUN_END] = run_end;
  assign irq_events[`IRQ_MATCH_A] = active & events_i.cmp_a & ~flag_a_reg;
  assign irq_events[`IRQ_MATCH_B] = active & events_i.cmp_b & ~flag_b_reg;

  event_irq_bank #(.N(IRQ_N)) u_irq (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .event_i   (irq_events),
    .clr_wr_i  (wr_clr),
    .en_wr_i   (wr_ien),
    .wdata_i   (acc.data[IRQ_N-1:0]),
    .status_o  (irq_status),
    .enable_o  (irq_enable),
    .irq_o     (irq_line)
  );

  always_ff @(posedge clk_i) begin
    if (sys_rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= irq_line;
  end

  // Read mux; status writes fall through to nothing
  wire rd_ctl = (acc.addr == `OFS_CONTROL);
  wire rd_sts = (acc.addr == `OFS_STATUS);
  wire rd_ist = (acc.addr == `OFS_IRQ_STATUS);
  wire rd_ien = (acc.addr == `OFS_IRQ_ENABLE);
  wire [7:0] ctl_byte = {enable_reg, arm_reg, begin_sel_reg, 5'h00};
  assign rd_data = rd_ctl ? {24'h000000, ctl_byte} :
                   rd_sts ? {24'h000000, status_byte} :
                   rd_ist ? {{(32-IRQ_N){1'b0}}, irq_status} :
                   rd_ien ? {{(32-IRQ_N){1'b0}}, irq_enable} : `RESET_WORD;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_arm_write;
    wr_ctl && new_arm && !active;
  endsequence
  sequence s_fresh_run;
    (count_reg == `CNT_EMPTY) && !flag_a_reg && !flag_b_reg;
  endsequence

  a_start_clears: assert property (s_arm_write |=> s_fresh_run)
    else $error("Run start did not clear flags and count");
  a_armed_shows: assert property (s_arm_write |=> status_byte[`ST_ARMED_STATUS_FLAG_BIT] ##0 armed_o)
    else $error("Armed flag not set after arming");
  a_armed_status_flag_mirror: assert property (status_byte[`ST_ARMED_STATUS_FLAG_BIT] == (enable_reg && arm_reg))
    else $error("Armed flag differs from arm and enable");
  a_flag_a_set: assert property (active && !start_run && events_i.cmp_a |=> flag_a_reg)
    else $error("Comparator A match not recorded");
  a_flag_b_set: assert property (active && !start_run && events_i.cmp_b |=> flag_b_reg)
    else $error("Comparator B match not recorded");
  a_trig_ends: assert property (trig_end |=> !armed_o && !status_byte[`ST_ARMED_STATUS_FLAG_BIT])
    else $error("End trace trigger did not end run");
  a_full_ends: assert property (fill_end |=> count_reg == `CNT_FULL && !armed_o)
    else $error("Full FIFO did not end begin trace run");
  a_manual_end: assert property (manual_end |=> state_reg == RUN_IDLE)
    else $error("Manual stop did not end run");
  a_count_holds: assert property (!active && !start_run |=> $stable(count_reg))
    else $error("Count changed outside a run");
  a_count_range: assert property (count_reg <= `CNT_FULL)
    else $error("Count above eight");
  a_flags_hold: assert property (!active && !start_run |=>
    $stable(flag_a_reg) && $stable(flag_b_reg))
    else $error("Match flag changed after run end");
  a_begin_waits: assert property (state_reg == RUN_WAIT_TRIG && !events_i.trigger
    && !manual_end |=> !capture_o)
    else $error("Begin trace captured before trigger");
  a_status_ro: assert property (acc.wr && rd_sts && !active |=> $stable(status_byte))
    else $error("Status register changed by a write");

  // Arming and run end keep the armed flag equal to run activity
  a_armed_status_flag_tracks: assert property (status_byte[`ST_ARMED_STATUS_FLAG_BIT] == active)
    else $error("Armed flag differs from run activity");
  a_ctl_write: assert property (wr_ctl && !run_end |=> arm_reg == $past(new_arm))
    else $error("Arm bit not taken from control write");
  a_arm_drops: assert property (run_end |=> !arm_reg)
    else $error("Arm bit still set after run end");
  a_run_end_irq: assert property (run_end |=> irq_status[`IRQ_RUN_END])
    else $error("Run end not recorded as interrupt status");

  // Match events raise their interrupt status
  a_match_a_irq: assert property (irq_events[`IRQ_MATCH_A] |=> irq_status[`IRQ_MATCH_A])
    else $error("First A match not recorded as interrupt status");
  a_match_b_irq: assert property (irq_events[`IRQ_MATCH_B] |=> irq_status[`IRQ_MATCH_B])
    else $error("First B match not recorded as interrupt status");

  // Capture counting
  a_count_steps: assert property (store && !count_full |=>
    count_reg == $past(count_reg) + `CNT_ONE)
    else $error("Stored word not counted");
  a_no_decrement: assert property (!start_run |=> count_reg >= $past(count_reg))
    else $error("Count decreased without a run start");
  a_sat_holds: assert property (count_full && !start_run |=> count_full)
    else $error("Count left eight without a run start");
  a_wait_no_store: assert property (state_reg == RUN_WAIT_TRIG |=> $stable(count_reg))
    else $error("Word counted before begin trace trigger");

  // Capture mode held for the whole run
  sequence s_trig_in_wait;
    (state_reg == RUN_WAIT_TRIG) && events_i.trigger && !manual_end;
  endsequence
  a_trigger_starts: assert property (s_trig_in_wait |=>
    (state_reg == RUN_CAPTURE) ##0 capture_o)
    else $error("Begin trace trigger did not start capture");
  a_start_mode: assert property (s_arm_write |=> mode_begin_reg == $past(begin_sel_reg))
    else $error("Run mode not taken at run start");
  a_mode_fixed: assert property (active |=> $stable(mode_begin_reg))
    else $error("Run mode changed within a run");
  a_idle_no_capture: assert property (!armed_o |-> !capture_o)
    else $error("Capture flagged while not armed");
  a_begin_trig_keeps: assert property (mode_begin_reg && (state_reg == RUN_CAPTURE)
    && events_i.trigger && !fill_end && !manual_end |=> state_reg == RUN_CAPTURE)
    else $error("Trigger ended a begin trace run");
endmodule

// ==== rtl/debug_run_defines.svh ====
`ifndef DEBUG_RUN_DEFINES_SVH
`define DEBUG_RUN_DEFINES_SVH

// Register byte offsets on the bus
`define OFS_CONTROL     8'h00
`define OFS_STATUS      8'h04
`define OFS_IRQ_STATUS  8'h08
`define OFS_IRQ_CLEAR   8'h0c
`define OFS_IRQ_ENABLE  8'h10

// Control register fields
`define CTL_EN_BIT      7
`define CTL_ARM_BIT     6
`define CTL_BEGIN_BIT   5

// Status register fields
`define ST_AF_BIT       7
`define ST_BF_BIT       6
`define ST_ARMED_STATUS_FLAG_BIT     5
`define ST_CNT_MSB      3

// Count encoding
`define CNT_EMPTY       4'h0
`define CNT_ONE         4'h1
`define CNT_FULL        4'h8

// Interrupt status layout
`define IRQ_RUN_END     0
`define IRQ_MATCH_A     1
`define IRQ_MATCH_B     2
`define IRQ_COUNT       3

// Bus constants
`define ADDR_W          8
`define HTRANS_NONSEQ   2'h2
`define RESET_BYTE      8'h00
`define RESET_WORD      32'h0000_0000

`endif

// ==== rtl/debug_run_pkg.sv ====
package debug_run_pkg;
  `include "debug_run_defines.svh"

  // Address phase of the bus
  typedef struct packed {
    logic                 sel;
    logic [1:0]           trans;
    logic                 write;
    logic [`ADDR_W-1:0]   addr;
  } ahb_addr_t;

  // One register access, pulsed in the data phase
  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic [`ADDR_W-1:0]   addr;
    logic [31:0]          data;
  } reg_access_t;

  // Debug-side events, single-cycle pulses
  typedef struct packed {
    logic                 cmp_a;
    logic                 cmp_b;
    logic                 trigger;
    logic                 word;
  } debug_events_t;

  typedef enum logic [1:0] {RUN_IDLE, RUN_WAIT_TRIG, RUN_CAPTURE} run_state_t;
endpackage

// ==== rtl/ahb_reg_port.sv ====
`timescale 1ns/1ps
`include "debug_run_defines.svh"
module ahb_reg_port (
  input  wire logic                     clk_i,
  input  wire logic                     sys_rst_i,
  input  wire debug_run_pkg::ahb_addr_t aphase_i,
  input  wire logic                     hready_i,
  input  wire logic [31:0]              hwdata_i,
  input  wire logic [31:0]              rd_data_i,
  output      debug_run_pkg::reg_access_t acc_o,
  output      logic                     hreadyout_o,
  output      logic [31:0]              hrdata_o,
  output      logic                     hresp_o
);
  import debug_run_pkg::*;

  logic               pend_reg;
  logic               write_reg;
  logic [`ADDR_W-1:0] addr_reg;
  wire                take;

  // Address phase accepted on a valid NONSEQ transfer
  assign take  = aphase_i.sel & hready_i & (aphase_i.trans == `HTRANS_NONSEQ);
  assign acc_o = '{wr: pend_reg & write_reg, rd: pend_reg & ~write_reg,
                   addr: addr_reg, data: hwdata_i};

  // One wait state, then data phase completes
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pend_reg    <= 1'b0;
      write_reg   <= 1'b0;
      addr_reg    <= '0;
      hreadyout_o <= 1'b1;
      hrdata_o    <= `RESET_WORD;
      hresp_o     <= 1'b0;
    end else if (pend_reg) begin
      pend_reg    <= 1'b0;
      hreadyout_o <= 1'b1;
      hrdata_o    <= write_reg ? `RESET_WORD : rd_data_i;
    end else if (take) begin
      pend_reg    <= 1'b1;
      write_reg   <= aphase_i.write;
      addr_reg    <= aphase_i.addr;
      hreadyout_o <= 1'b0;
    end
  end

  a_wait_state_one: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (take && !pend_reg) |=> !hreadyout_o ##1 hreadyout_o)
    else $error("Bus answer not after exactly one wait state");
endmodule

// ==== rtl/event_irq_bank.sv ====
`timescale 1ns/1ps
module event_irq_bank #(
  parameter int N = 3
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [N-1:0] event_i,
  input  wire logic         clr_wr_i,
  input  wire logic         en_wr_i,
  input  wire logic [N-1:0] wdata_i,
  output      logic [N-1:0] status_o,
  output      logic [N-1:0] enable_o,
  output      logic         irq_o
);
  logic [N-1:0] status_next;

  // Per-bit sticky flag, set wins over clear
  for (genvar i = 0; i < N; i++) begin : g_flag
    assign status_next[i] = event_i[i] | (status_o[i] & ~(clr_wr_i & wdata_i[i]));
  end

  // Status, enable and level interrupt
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      status_o <= '0;
      enable_o <= '0;
      irq_o    <= 1'b0;
    end else begin
      status_o <= status_next;
      if (en_wr_i)
        enable_o <= wdata_i;
      irq_o    <= |(status_next & (en_wr_i ? wdata_i : enable_o));
    end
  end

  a_irq_follows: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ##1 (irq_o == |(status_o & enable_o)))
    else $error("Interrupt level disagrees with enabled status");
  a_set_wins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (event_i != '0) |=> ((status_o & $past(event_i)) == $past(event_i)))
    else $error("Event lost against a clear");
endmodule

// ==== test/debug_host_model.sv ====
`timescale 1ns/1ps
module debug_host_model (
  input  wire logic        clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output      logic        hsel_o,
  output      logic [7:0]  haddr_o,
  output      logic [1:0]  htrans_o,
  output      logic        hwrite_o,
  output      logic [31:0] hwdata_o
);
  int tally;

  // Bus idle from time zero
  initial begin
    hsel_o = 1'b0;
    haddr_o = 8'h00;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hwdata_o = 32'h0;
    tally = 0;
  end

  // One whole-word transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel_o <= 1'b1;
    haddr_o <= a;
    hwrite_o <= w;
    htrans_o <= 2'h2;
    @(posedge clk_i);
    while (hready_i !== 1'b1) @(posedge clk_i);
    htrans_o <= 2'h0;
    hwdata_o <= d;
    @(posedge clk_i);
    while (hready_i !== 1'b1) @(posedge clk_i);
    // Select stays up; htrans IDLE keeps the slave quiet between transfers
    r = hrdata_i;
  endtask

  // Read the status word, then reread it once per counted word, counting down its own tally from the count
  task automatic drain(output logic [31:0] last);
    xfer(1'b0, 8'h04, 32'h0, last);
    tally = int'(last[3:0]);
    while (tally > 0) begin
      xfer(1'b0, 8'h04, 32'h0, last);
      tally--;
    end
  endtask
endmodule

// ==== test/debug_run_status_logic_tb.sv ====
`timescale 1ns/1ps
module debug_run_status_logic_tb;
  import debug_run_pkg::*;
  logic          clk_i = 1'b0;
  logic          sys_rst_i = 1'b1;
  debug_events_t ev = '0;
  logic          hsel;
  logic          hwrite;
  logic          hready;
  logic          hresp;
  logic          armed;
  logic          irq;
  logic          capture;
  logic [7:0]    haddr;
  logic [1:0]    htrans;
  logic [31:0]   hwdata;
  logic [31:0]   hrdata;
  logic [31:0]   r;
  int            bad_count = 0;
  int            cmp_count = 0;
  int            cyc = 0;
  int            n;

  always #25 clk_i = ~clk_i;

  debug_run_status_logic debug_run_status_logic_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready),
    .hwdata_i(hwdata), .events_i(ev), .hreadyout_o(hready), .hrdata_o(hrdata),
    .hresp_o(hresp), .armed_o(armed), .capture_o(capture), .irq_o(irq)
  );

  debug_host_model debug_host_model_i (
    .clk_i(clk_i), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hwdata_o(hwdata)
  );

  // Expected status word
  function automatic logic [31:0] st(logic a, logic b, logic m, logic [3:0] c);
    return {24'h0, a, b, m, 1'b0, c};
  endfunction

  // Saturating word count of a circular capture
  function automatic logic [3:0] sat(int k);
    return (k > 8) ? 4'h8 : 4'(k);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a);
    debug_host_model_i.xfer(1'b0, a, 32'h0, r);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    debug_host_model_i.xfer(1'b1, a, d, r);
  endtask

  // Single-cycle event pulses with a gap
  task automatic pulse(input logic [3:0] v, input int k);
    repeat (k) begin
      ev <= v;
      @(posedge clk_i);
      ev <= '0;
      @(posedge clk_i);
    end
  endtask

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    n = $urandom(32'h5afdbba4);
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset values, unmapped place, write to the read-only status
    rd(8'h04);
    chk(r, st(0, 0, 0, 4'h0));
    rd(8'h20);
    chk(r, 32'h0);
    wr(8'h04, 32'hff);
    rd(8'h04);
    chk(r, st(0, 0, 0, 4'h0));
    $display("test reset done");
    // End trace: arm, match A, random word total, trigger ends run
    wr(8'h00, 32'hc0);
    rd(8'h04);
    chk(r, st(0, 0, 1, 4'h0));
    chk({31'h0, armed}, 32'h1);
    chk({31'h0, capture}, 32'h1);
    pulse(4'h8, 1);
    n = $urandom_range(11, 1);
    pulse(4'h1, n);
    rd(8'h04);
    chk(r, st(1, 0, 1, sat(n)));
    pulse(4'h2, 1);
    rd(8'h04);
    chk(r, st(1, 0, 0, sat(n)));
    debug_host_model_i.drain(r);
    chk(r, st(1, 0, 0, sat(n)));
    $display("test end trace done");
    // Interrupts: masked, enabled, cleared
    chk({31'h0, irq}, 32'h0);
    rd(8'h08);
    chk(r, 32'h3);
    wr(8'h10, 32'h7);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    wr(8'h0c, 32'h7);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    rd(8'h08);
    chk(r, 32'h0);
    $display("test interrupt done");
    // Begin trace: early word ignored, trigger starts storage, eighth word ends
    wr(8'h00, 32'h20);
    wr(8'h00, 32'he0);
    rd(8'h04);
    chk(r, st(0, 0, 1, 4'h0));
    chk({31'h0, capture}, 32'h0);
    pulse(4'h1, 1);
    pulse(4'h4, 1);
    pulse(4'h2, 1);
    chk({31'h0, capture}, 32'h1);
    pulse(4'h1, 8);
    rd(8'h04);
    chk(r, st(0, 1, 0, 4'h8));
    chk({31'h0, capture}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    pulse(4'hc, 1);
    rd(8'h04);
    chk(r, st(0, 1, 0, 4'h8));
    $display("test begin trace done");
    // Manual ends by clearing arm, then by clearing enable
    wr(8'h00, 32'hc0);
    rd(8'h04);
    chk(r, st(0, 0, 1, 4'h0));
    wr(8'h00, 32'h80);
    rd(8'h04);
    chk(r, st(0, 0, 0, 4'h0));
    wr(8'h00, 32'hc0);
    pulse(4'h4, 1);
    wr(8'h00, 32'h40);
    rd(8'h04);
    chk(r, st(0, 1, 0, 4'h0));
    chk({31'h0, armed}, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("test manual end done");
    print_verdict();
  end
endmodule
